/* File: design/boot_select_regs.vh */
/*
 * boot source decoder constants: addresses, codes, source classes, widths.
 * assumes inclusion by the decoder and its config register leaf only.
 */
`ifndef BOOT_SELECT_REGS_VH
`define BOOT_SELECT_REGS_VH

// ----------------------------------------------------------------
// fixed addresses
// ----------------------------------------------------------------
`define BOOT_ROM_ADDR      32'hef000000
`define PAR_FLASH_ADDR     32'h20000000
`define ZERO_ADDR          32'h00000000

// ----------------------------------------------------------------
// variant selection
// ----------------------------------------------------------------
`define VAR_FOUR_BIT       2'h0
`define VAR_THREE_OTP      2'h1
`define VAR_THREE_SYNC     2'h2
`define VAR_THREE_DUAL     2'h3

// ----------------------------------------------------------------
// boot source classes
// ----------------------------------------------------------------
`define SRC_IDLE           4'h0
`define SRC_PAR_FLASH      4'h1
`define SRC_SPI_MEM        4'h2
`define SRC_SPI_HOST       4'h3
`define SRC_UART_HOST      4'h4
`define SRC_NAND           4'h5
`define SRC_OTP            4'h6
`define SRC_SYNC_FLASH     4'h7

// ----------------------------------------------------------------
// port selectors
// ----------------------------------------------------------------
`define PORT_NONE          2'h0
`define PORT_FIRST         2'h1
`define PORT_SECOND        2'h2

// ----------------------------------------------------------------
// transfer sizing
// ----------------------------------------------------------------
`define NAND_BLOCK_BYTES   9'h100
`define OTP_XFER_WIDTH     6'h20

// ----------------------------------------------------------------
// config register field layout
// ----------------------------------------------------------------
`define CFG_PINS_LSB       0
`define CFG_VALID_BIT      4

`endif

/* File: design/system_config_reg.v */
/*
 * system configuration register: holds the pin levels seen at boot.
 * assumes pins are synchronous to clk_i and a capture strobe from the decoder.
 */
`timescale 1ns/1ns
`include "boot_select_regs.vh"

module system_config_reg #(
    parameter PIN_W = 4
) (
    input wire clk_i,
    input wire rstn_i,
    input wire capture_i,
    input wire [PIN_W-1:0] pins_i,
    output reg [7:0] value_o
);

    // ----------------------------------------------------------------
    // capture
    // ----------------------------------------------------------------
    // pins copied into dedicated low bits, valid bit set once captured
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            value_o <= 8'h00;
        end else if (capture_i) begin
            value_o <= 8'h00;
            value_o[`CFG_PINS_LSB +: PIN_W] <= pins_i;
            value_o[`CFG_VALID_BIT] <= 1'b1;
        end
    end

endmodule

/* File: design/boot_source_mode_decoder.v */
/*
 * boot source mode decoder: samples the boot-select pins after reset,
 * decodes them per processor variant and drives the boot fetch engine.
 * assumes a boot memory or host outside, synchronous pins, one clock.
 */
`timescale 1ns/1ns
`include "boot_select_regs.vh"

module boot_source_mode_decoder #(
    parameter PIN_W = 4,
    parameter VARIANT = 0,
    parameter SUB_FAMILY = 0,
    parameter HAS_INT_FLASH = 1
) (
    input wire clk_i,
    input wire rstn_i,
    input wire [PIN_W-1:0] boot_select_pins_i,
    input wire fetch_ack_i,
    input wire host_valid_i,
    output reg [31:0] fetch_addr_o,
    output reg [3:0] boot_source_o,
    output reg [1:0] port_sel_o,
    output reg master_mode_o,
    output reg slave_mode_o,
    output reg fetch_req_o,
    output reg prefetch_req_o,
    output reg [31:0] prefetch_addr_o,
    output reg [5:0] xfer_width_o,
    output reg boot_busy_o,
    output reg [7:0] system_config_reg_o
);

    // ----------------------------------------------------------------
    // state machine codes
    // ----------------------------------------------------------------
    // rom entry always comes first, whatever the pins say
    localparam ST_RESET = 3'h0;
    localparam ST_ROM = 3'h1;
    localparam ST_MASTER = 3'h2;
    localparam ST_SLAVE = 3'h3;
    localparam ST_IDLE = 3'h4;

    // sequencer state, held code and block bookkeeping
    reg [2:0] state_q;
    reg sampled_q;
    reg [PIN_W-1:0] code_q;
    reg capture_q;
    reg [31:0] block_addr_q;
    wire [7:0] cfg_value;

    // ----------------------------------------------------------------
    // decode functions
    // ----------------------------------------------------------------
    // source class from code and variant; unknown codes fall to idle
    function [3:0] decode_src;
        input [3:0] code;
        input [1:0] variant;
        input has_flash;
        begin
            decode_src = `SRC_IDLE;
            case (variant)
                `VAR_FOUR_BIT: begin
                    case (code)
                        4'h1: decode_src = `SRC_PAR_FLASH;
                        4'h3: decode_src = `SRC_SPI_MEM;
                        4'h4: decode_src = `SRC_SPI_HOST;
                        4'h7: decode_src = `SRC_UART_HOST;
                        4'hc: decode_src = `SRC_NAND;
                        4'hd: decode_src = `SRC_NAND;
                        default: decode_src = `SRC_IDLE;
                    endcase
                end
                `VAR_THREE_OTP: begin
                    case (code[2:0])
                        3'h3: decode_src = `SRC_SPI_MEM;
                        3'h5: decode_src = `SRC_OTP;
                        default: decode_src = `SRC_IDLE;
                    endcase
                end
                `VAR_THREE_SYNC: begin
                    case (code[2:0])
                        3'h2: decode_src = has_flash ? `SRC_SYNC_FLASH : `SRC_IDLE;
                        3'h4: decode_src = `SRC_SPI_HOST;
                        3'h7: decode_src = `SRC_UART_HOST;
                        default: decode_src = `SRC_IDLE;
                    endcase
                end
                `VAR_THREE_DUAL: begin
                    case (code[2:0])
                        3'h2: decode_src = `SRC_SPI_MEM;
                        3'h4: decode_src = `SRC_SPI_MEM;
                        3'h3: decode_src = `SRC_SPI_HOST;
                        default: decode_src = `SRC_IDLE;
                    endcase
                end
                default: decode_src = `SRC_IDLE;
            endcase
        end
    endfunction

    // which serial port the chosen source uses
    function [1:0] decode_port;
        input [3:0] code;
        input [1:0] variant;
        input sub_family;
        begin
            decode_port = `PORT_NONE;
            case (variant)
                `VAR_FOUR_BIT: begin
                    if (code == 4'h3 || code == 4'h4) begin
                        decode_port = `PORT_FIRST;
                    end else if (code == 4'h7) begin
                        decode_port = sub_family ? `PORT_SECOND : `PORT_FIRST;
                    end
                end
                `VAR_THREE_OTP: begin
                    if (code[2:0] == 3'h3) begin
                        decode_port = `PORT_FIRST;
                    end
                end
                `VAR_THREE_SYNC: begin
                    if (code[2:0] == 3'h4 || code[2:0] == 3'h7) begin
                        decode_port = `PORT_FIRST;
                    end
                end
                `VAR_THREE_DUAL: begin
                    if (code[2:0] == 3'h2 || code[2:0] == 3'h3) begin
                        decode_port = `PORT_SECOND;
                    end else if (code[2:0] == 3'h4) begin
                        decode_port = `PORT_FIRST;
                    end
                end
                default: decode_port = `PORT_NONE;
            endcase
        end
    endfunction

    // start address of memory sources
    function [31:0] start_addr;
        input [3:0] src;
        begin
            case (src)
                `SRC_PAR_FLASH: start_addr = `PAR_FLASH_ADDR;
                `SRC_SYNC_FLASH: start_addr = `PAR_FLASH_ADDR;
                default: start_addr = `ZERO_ADDR;
            endcase
        end
    endfunction

    // master sources are those the processor reads itself
    function is_master;
        input [3:0] src;
        begin
            is_master = (src == `SRC_PAR_FLASH) || (src == `SRC_SPI_MEM) ||
                        (src == `SRC_NAND) || (src == `SRC_OTP) ||
                        (src == `SRC_SYNC_FLASH);
        end
    endfunction

    // slave sources wait for a host to push the image
    function is_slave;
        input [3:0] src;
        begin
            is_slave = (src == `SRC_SPI_HOST) || (src == `SRC_UART_HOST);
        end
    endfunction

    // address one nand block past the given one
    function [31:0] next_block;
        input [31:0] addr;
        begin
            next_block = addr + {23'h000000, `NAND_BLOCK_BYTES};
        end
    endfunction

    // ----------------------------------------------------------------
    // decoded view of the held code
    // ----------------------------------------------------------------
    // only the low bits of the parameters matter; wider values wrap
    wire [1:0] variant_w = VARIANT[1:0];
    // held code widened to four bits; three-bit parts see a zero top bit
    reg [3:0] code4;
    always @* begin
        code4 = 4'h0;
        code4[PIN_W-1:0] = code_q;
    end
    wire [3:0] src_w = decode_src(code4, variant_w, HAS_INT_FLASH[0]);
    wire [1:0] port_w = decode_port(code4, variant_w, SUB_FAMILY[0]);

    // ----------------------------------------------------------------
    // config register leaf
    // ----------------------------------------------------------------
    system_config_reg #(
        .PIN_W(PIN_W)
    ) u_cfg (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .capture_i(capture_q),
        .pins_i(code_q),
        .value_o(cfg_value)
    );

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    // one-shot sample at first edge after release; later pin changes are
    // ignored so a bouncing strap cannot switch the source mid-boot
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sampled_q <= 1'b0;
            code_q <= {PIN_W{1'b0}};
            capture_q <= 1'b0;
        end else begin
            capture_q <= 1'b0;
            if (!sampled_q) begin
                sampled_q <= 1'b1;
                code_q <= boot_select_pins_i;
                capture_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // boot sequencer
    // ----------------------------------------------------------------
    // rom first, then master reads, slave wait or idle
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_RESET;
            fetch_addr_o <= `BOOT_ROM_ADDR;
            boot_source_o <= `SRC_IDLE;
            port_sel_o <= `PORT_NONE;
            master_mode_o <= 1'b0;
            slave_mode_o <= 1'b0;
            fetch_req_o <= 1'b0;
            prefetch_req_o <= 1'b0;
            prefetch_addr_o <= `ZERO_ADDR;
            xfer_width_o <= 6'h00;
            boot_busy_o <= 1'b0;
            block_addr_q <= `ZERO_ADDR;
        end else begin
            case (state_q)
                ST_RESET: begin
                    fetch_addr_o <= `BOOT_ROM_ADDR;
                    fetch_req_o <= 1'b1;
                    boot_busy_o <= 1'b1;
                    state_q <= ST_ROM;
                end
                ST_ROM: begin
                    // code is already held once the rom fetch is acknowledged
                    if (fetch_ack_i) begin
                        boot_source_o <= src_w;
                        port_sel_o <= port_w;
                        fetch_req_o <= 1'b0;
                        if (is_master(src_w)) begin
                            // memory sources: start reading at the source's base
                            master_mode_o <= 1'b1;
                            block_addr_q <= start_addr(src_w);
                            fetch_addr_o <= start_addr(src_w);
                            fetch_req_o <= 1'b1;
                            xfer_width_o <= (src_w == `SRC_OTP) ?
                                            `OTP_XFER_WIDTH : 6'h00;
                            state_q <= ST_MASTER;
                        end else if (is_slave(src_w)) begin
                            // host sources: no reads, wait for pushed data
                            slave_mode_o <= 1'b1;
                            state_q <= ST_SLAVE;
                        end else begin
                            // reserved or unsupported code parks with no transfer
                            boot_busy_o <= 1'b0;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_MASTER: begin
                    // nand overlaps the next block fetch with the current one
                    if (boot_source_o == `SRC_NAND) begin
                        prefetch_req_o <= 1'b1;
                        prefetch_addr_o <= next_block(block_addr_q);
                    end
                    if (fetch_ack_i) begin
                        if (boot_source_o == `SRC_NAND) begin
                            // prefetch moves with the block so it stays one ahead
                            block_addr_q <= next_block(block_addr_q);
                            fetch_addr_o <= next_block(block_addr_q);
                            prefetch_addr_o <= next_block(next_block(block_addr_q));
                        end else begin
                            // word-wide reads step by four bytes
                            fetch_addr_o <= fetch_addr_o + 32'h00000004;
                        end
                    end
                end
                ST_SLAVE: begin
                    // no reads issued; data only arrives from the host
                    fetch_req_o <= 1'b0;
                    // busy stays up once the host has started pushing
                    boot_busy_o <= host_valid_i | boot_busy_o;
                end
                ST_IDLE: begin
                    // parked until the next reset
                    fetch_req_o <= 1'b0;
                    prefetch_req_o <= 1'b0;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register copy for software
    // ----------------------------------------------------------------
    // extra stage so the output comes straight from a flop of this module
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            system_config_reg_o <= 8'h00;
        end else begin
            system_config_reg_o <= cfg_value;
        end
    end

endmodule

/* File: bench/boot_decoder_monitor.sv */
/* checker of the boot decoder outputs against the boot rules.
   assumes one clock, async active-low reset, bound to every decoder instance. */
`timescale 1ns/1ns
module boot_decoder_monitor (
    input wire clk_i,
    input wire rstn_i,
    input wire fetch_ack_i,
    input wire [31:0] fetch_addr_o,
    input wire [3:0] boot_source_o,
    input wire [1:0] port_sel_o,
    input wire master_mode_o,
    input wire slave_mode_o,
    input wire fetch_req_o,
    input wire prefetch_req_o,
    input wire [31:0] prefetch_addr_o,
    input wire [5:0] xfer_width_o,
    input wire boot_busy_o,
    input wire [7:0] system_config_reg_o
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    // one domain, so clock and reset are stated once here
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_rom_entry;
        $rose(fetch_req_o) && boot_source_o == 4'h0 |-> fetch_addr_o == 32'hef000000;
    endproperty
    a_rom_entry: assert property (p_rom_entry)
        else $error("first fetch not at boot rom");
    property p_hold_mode;
        boot_source_o != 4'h0 |=> $stable(boot_source_o) && $stable(port_sel_o);
    endproperty
    a_hold_mode: assert property (p_hold_mode)
        else $error("boot source changed after decode");
    property p_slave_quiet;
        slave_mode_o |-> !fetch_req_o && !prefetch_req_o && !master_mode_o;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet)
        else $error("fetch issued in slave mode");
    property p_idle_quiet;
        !boot_busy_o |-> !fetch_req_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("fetch while not busy");
    property p_word_step;
        master_mode_o && fetch_req_o && fetch_ack_i && boot_source_o inside {4'h1, 4'h2, 4'h7}
        |=> fetch_addr_o == $past(fetch_addr_o) + 32'h4;
    endproperty
    a_word_step: assert property (p_word_step)
        else $error("master fetch address did not step by four");
    property p_nand_step;
        master_mode_o && fetch_req_o && fetch_ack_i && boot_source_o == 4'h5
        |=> fetch_addr_o == $past(fetch_addr_o) + 32'h100;
    endproperty
    a_nand_step: assert property (p_nand_step)
        else $error("nand address did not step by one block");
    property p_prefetch;
        prefetch_req_o |-> boot_source_o == 4'h5 && prefetch_addr_o == fetch_addr_o + 32'h100;
    endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("prefetch not one block ahead");
    property p_otp_width;
        1'b1 |-> xfer_width_o == ((boot_source_o == 4'h6) ? 6'h20 : 6'h00);
    endproperty
    a_otp_width: assert property (p_otp_width)
        else $error("transfer width wrong for source");
    property p_cfg_hold;
        system_config_reg_o[4] |=> $stable(system_config_reg_o);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("config register changed after capture");
endmodule
bind boot_source_mode_decoder boot_decoder_monitor u_mon (.clk_i, .rstn_i, .fetch_ack_i,
    .fetch_addr_o, .boot_source_o, .port_sel_o, .master_mode_o, .slave_mode_o, .fetch_req_o,
    .prefetch_req_o, .prefetch_addr_o, .xfer_width_o, .boot_busy_o, .system_config_reg_o);

/* File: bench/boot_far_side_model.sv */
/* far side of the boot decoder: boot memory answering reads, host pushing data.
   assumes the decoder holds its read request as a level until acknowledged. */
`timescale 1ns/1ns
module boot_far_side_model (
    input wire clk_i,
    input wire rstn_i,
    input wire fetch_req_i,
    input wire slave_i,
    input wire [1:0] delay_i,
    output reg fetch_ack_o,
    output reg host_valid_o,
    output reg [7:0] n_ack_o
);
    reg [1:0] wait_q;
    // memory answers only reads the decoder starts; delay sets slow or prompt
    // every read finds data, as an image padded by one block would give, so a
    // nand prefetch past the last real block never meets blank memory
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fetch_ack_o <= 1'b0;
            n_ack_o <= 8'h0;
            wait_q <= 2'h0;
        end else if (fetch_ack_o) begin
            fetch_ack_o <= 1'b0; // one-cycle pulse, else address would run on
            n_ack_o <= n_ack_o + 8'h1;
        end else if (fetch_req_i && wait_q >= delay_i) begin
            fetch_ack_o <= 1'b1;
            wait_q <= 2'h0;
        end else if (fetch_req_i) begin
            wait_q <= wait_q + 2'h1;
        end
    end
    // host pushes on its own in slave modes, toggling so a stuck input shows
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) host_valid_o <= 1'b0;
        else host_valid_o <= slave_i ? ~host_valid_o : 1'b0;
    end
    // parallel-port host and otp hex images are shaped by the image tools and
    // never cross these pins: fifo-aligned blocks, page-times-16 offsets
endmodule

/* File: bench/tb_boot_source_mode_decoder.sv */
/* testbench: six decoder variants side by side, each with its far-side model.
   assumes the hand-over timing: pins sampled at first edge after reset release. */
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_boot_source_mode_decoder;
    localparam logic [39:0] k_src = 40'hf000000000;
    localparam logic [39:0] k_port = 40'h0c00000000;
    localparam logic [39:0] k_ms = 40'h0300000000;
    localparam logic [39:0] k_addr = 40'h00ffffffff;
    logic clk_i, rstn_i;
    logic [3:0] pins, cur;
    logic [1:0] dly;
    int n_errors = 0, n_tests = 0, i;
    event rom_ev, commit_ev;
    // ----------------------------------------------------------------
    // expected decode
    // ----------------------------------------------------------------
    function automatic logic [39:0] mk(input logic [3:0] s, input logic [1:0] p,
                                       input logic m, input logic sl, input logic [31:0] a);
        mk = {s, p, m, sl, a};
    endfunction
    // result is {mask, value}; codes the rules leave open get a zero mask, so only the captured pins are checked
    function automatic logic [79:0] expect_of(input int g, input logic [3:0] c);
        logic [79:0] r;
        logic [79:0] idle;
        logic [1:0] p7;
        idle = {k_src | k_ms, 40'h0};
        r = 80'h0;
        p7 = (g == 5) ? 2'h2 : 2'h1;
        if (g % 5 == 0) begin
            case (c)
                4'h0, 4'h9: r = idle;
                4'h1: r = {k_src | k_ms | k_addr, mk(4'h1, 2'h0, 1, 0, 32'h20000000)};
                4'h3: r = {k_src | k_ms | k_addr, mk(4'h2, 2'h0, 1, 0, 32'h0)};
                4'h4: r = {k_src | k_ms, mk(4'h3, 2'h0, 0, 1, 32'h0)};
                4'h7: r = {k_src | k_port | k_ms, mk(4'h4, p7, 0, 1, 32'h0)};
                4'hc, 4'hd: r = {k_src | k_ms | k_addr, mk(4'h5, 2'h0, 1, 0, 32'h0)};
                default: r = 80'h0;
            endcase
        end else begin
            case (c[2:0])
                3'h0: r = idle;
                3'h2: if (g == 2) r = {k_src | k_ms | k_addr, mk(4'h7, 0, 1, 0, 32'h20000000)};
                    else if (g == 4) r = idle;
                    else if (g == 3) r = {k_src | k_port | k_ms, mk(4'h2, 2, 1, 0, 0)};
                3'h3: if (g == 1) r = {k_src | k_port | k_ms | k_addr, mk(4'h2, 1, 1, 0, 0)};
                    else if (g == 3) r = {k_src | k_port | k_ms, mk(4'h3, 2, 0, 1, 0)};
                3'h4: if (g == 3) r = {k_src | k_port | k_ms, mk(4'h2, 2'h1, 1, 0, 0)};
                    else if (g != 1) r = {k_src | k_port | k_ms, mk(4'h3, 1, 0, 1, 0)};
                3'h5: if (g == 1) r = {k_src, mk(4'h6, 0, 0, 0, 0)};
                3'h7: if (g == 2 || g == 4) r = {k_src | k_port | k_ms, mk(4'h4, 1, 0, 1, 0)};
                default: r = 80'h0;
            endcase
        end
        expect_of = r;
    endfunction
    // ----------------------------------------------------------------
    // decoders and far sides
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 6; g++) begin : v
        localparam int W = (g == 0 || g == 5) ? 4 : 3;
        wire [31:0] addr, paddr;
        wire [3:0] src;
        wire [1:0] port;
        wire m, s, req, preq, busy, ack, hv;
        wire [5:0] xw;
        wire [7:0] cfg, nack;
        logic [79:0] x;
        logic [7:0] cm;
        logic [31:0] st;
        boot_source_mode_decoder #(.PIN_W(W), .VARIANT(g == 4 ? 2 : g % 5), .SUB_FAMILY(g == 5),
            .HAS_INT_FLASH(g == 4 ? 0 : 1)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
            .boot_select_pins_i(pins[W-1:0]), .fetch_ack_i(ack), .host_valid_i(hv),
            .fetch_addr_o(addr), .boot_source_o(src), .port_sel_o(port), .master_mode_o(m),
            .slave_mode_o(s), .fetch_req_o(req), .prefetch_req_o(preq),
            .prefetch_addr_o(paddr), .xfer_width_o(xw), .boot_busy_o(busy),
            .system_config_reg_o(cfg));
        boot_far_side_model pm (.clk_i(clk_i), .rstn_i(rstn_i), .fetch_req_i(req),
            .slave_i(s), .delay_i(dly), .fetch_ack_o(ack), .host_valid_o(hv), .n_ack_o(nack));
        // first fetch of every variant comes from the boot rom
        always @(rom_ev) begin
            `CHK({req, busy, addr}, {2'b11, 32'hef000000})
        end
        // decode, captured pins, then fetch behaviour a few acks later
        always @(commit_ev) begin
            x = expect_of(g, cur);
            cm = (W == 4) ? 8'h1f : 8'h17;
            `CHK(cfg & cm, {3'h0, 1'b1, cur} & cm)
            `CHK({src, port, m, s, addr} & x[79:40], x[39:0] & x[79:40])
            if (x[79] && x[39:36] == 4'h0) `CHK({busy, req}, 2'b00)
            if (x[73] && x[33]) `CHK(req, 1'b1)
            if (x[72] && x[32]) `CHK(req, 1'b0)
            repeat (2) @(negedge clk_i);
            if (x[79] && x[39:36] == 4'h5) `CHK(preq, 1'b1)
            repeat (8) @(negedge clk_i);
            st = (x[39:36] == 4'h5) ? 32'h100 : 32'h4;
            if (x[33] && x[40] && x[39:36] != 4'h0)
                `CHK(addr, x[31:0] + ({24'h0, nack} - 32'h1) * st)
        end
    end
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // one boot: reset with a code strapped, disturb pins, follow the walk
    task run_one(input logic [3:0] c);
        begin
            @(negedge clk_i);
            rstn_i = 1'b0;
            pins = c;
            cur = c;
            dly = 2'($urandom % 4);
            repeat (2) @(negedge clk_i);
            rstn_i = 1'b1;
            @(negedge clk_i);
            pins = 4'($urandom); // late pin change must be ignored
            for (i = 0; i < 8 && v[0].req !== 1'b1; i++) @(negedge clk_i);
            -> rom_ev;
            for (i = 0; i < 16 && v[0].nack !== 8'h1; i++) @(negedge clk_i);
            `CHK(v[0].nack, 8'h1)
            -> commit_ev;
            repeat (12) @(negedge clk_i);
            $display("boot test code %h done", c);
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // hang guard: 32 boots of about 20 cycles each, about fifteen-fold margin
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        rstn_i = 1'b0;
        pins = 4'h0;
        cur = 4'h0;
        dly = 2'h0;
        void'($urandom(32'h2028));
        repeat (12) @(negedge clk_i);
        for (int c = 0; c < 16; c++) run_one(4'(c));
        repeat (16) run_one(4'($urandom));
        report_and_stop();
    end
endmodule
